// file: ssp_host_model.sv
`timescale 1ns/1ps
module ssp_host_model (
   input  wire logic pin_in,
   input  wire logic oe_in,
   output logic      sclk_out,
   output logic      sen_out,
   output logic      sdi_out
);
   initial begin
      sclk_out = 1'b0;
      sen_out  = 1'b0;
      sdi_out  = 1'b0;
   end
   // whole frame before the next one keeps writes in order
   task automatic frame(input logic rw, input logic [5:0] idx, input logic [23:0] d,
                        output logic [23:0] q);
      logic [31:0] w;
      w = {rw, idx, d[23:0], 1'b0};
      q = 'z;
      sen_out = 1'b1;
      #100;
      for (int i = 31; i >= 0; i--) begin
         sdi_out = w[i];
         #100;
         // sampled just before the next rise, long after the pin settles
         if (i < 24)
            q[i] = oe_in ? pin_in : 1'bz;
         sclk_out = 1'b1;
         #100 sclk_out = 1'b0;
      end
      #100 sen_out = 1'b0;
      sdi_out = ~sdi_out;
      #100;
   endtask
endmodule

// file: ssp_pkg.sv
package ssp_pkg;

   // ---------------------------------------------------------------
   // register map (index; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int          REG_AW          = 6;
   localparam int          REG_DW          = 24;
   localparam int          MEM_DEPTH       = 16;
   localparam logic [5:0]  IDX_ID          = 6'h00;
   localparam logic [5:0]  IDX_CHIPEN      = 6'h01;
   localparam logic [5:0]  IDX_REFDIV      = 6'h02;
   localparam logic [5:0]  IDX_INTDIV      = 6'h03;
   localparam logic [5:0]  IDX_FRACDIV     = 6'h04;
   localparam logic [5:0]  IDX_VCO_RELAY   = 6'h05;
   localparam logic [5:0]  IDX_MODE        = 6'h06;
   localparam logic [5:0]  IDX_AFC         = 6'h0a;
   localparam logic [5:0]  IDX_READBACK    = 6'h0f;
   localparam logic [5:0]  IDX_STATUS      = 6'h10;

   // ---------------------------------------------------------------
   // reset values and fields
   // ---------------------------------------------------------------
   localparam logic [23:0] RST_CHIPEN      = 24'h000002;
   localparam logic [23:0] RST_REFDIV      = 24'h000001;
   localparam logic [23:0] RST_INTDIV      = 24'h0000c8;
   localparam logic [23:0] RST_OTHER       = 24'h000000;
   localparam int          CHIPEN_BIT      = 1;
   localparam int          AFC_OFF_BIT     = 11;
   localparam int          FRAC_EN_BIT     = 11;
   localparam int          RB_MODE_HI      = 7;
   localparam int          RB_MODE_LO      = 6;
   localparam int          GPO_SEL_W       = 5;
   localparam int          ST_BUSY_BIT     = 0;
   localparam int          ST_LOCK_BIT     = 1;
   localparam int          ST_PEND_BIT     = 2;

   // ---------------------------------------------------------------
   // serial frame and timing
   // ---------------------------------------------------------------
   localparam logic [5:0]  HDR_LAST_BIT    = 6'd6;
   localparam logic [5:0]  FRAME_LAST_BIT  = 6'd31;
   localparam int          SEARCH_CMP_PERIODS = 8000;
   localparam int          CLK_PERIOD_NS   = 25;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   typedef enum logic [1:0] {
      RB_DATA_HIZ   = 2'b00,
      RB_GPO_HIZ    = 2'b01,
      RB_DATA_GPO   = 2'b10,
      RB_GPO_ALWAYS = 2'b11
   } ssp_rb_mode_t;

   typedef enum logic [1:0] {
      SS_IDLE  = 2'b00,
      SS_HEAD  = 2'b01,
      SS_WRITE = 2'b10,
      SS_READ  = 2'b11
   } ssp_ser_state_t;

   typedef struct packed {
      logic              en;
      logic [5:0]        idx;
      logic [23:0]       data;
   } ssp_wr_t;

endpackage

// file: ssp_reg_mem.sv
`timescale 1ns/1ps
module ssp_reg_mem
   import ssp_pkg::*;
#(
   parameter int DEPTH = ssp_pkg::MEM_DEPTH
) (
   input  wire logic           clk_in,
   input  wire logic           rst_n_in,
   input  wire ssp_pkg::ssp_wr_t wr_in,
   input  wire logic [5:0]     rd_a_idx_in,
   input  wire logic [5:0]     rd_b_idx_in,
   output logic [23:0]         rd_a_data_out,
   output logic [23:0]         rd_b_data_out
);
   import ssp_pkg::*;

   logic [23:0] mem_reg [DEPTH];

   function automatic logic [23:0] reset_value(input int idx);
      case (idx)
         1:       reset_value = RST_CHIPEN;
         2:       reset_value = RST_REFDIV;
         3:       reset_value = RST_INTDIV;
         default: reset_value = RST_OTHER;
      endcase
   endfunction

   // -----------------------------------------------------------
   // storage; the identity slot is never written
   // -----------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= reset_value(i);
         end
      end else if (wr_in.en && wr_in.idx != IDX_ID && wr_in.idx < 6'(DEPTH)) begin
         mem_reg[wr_in.idx[3:0]] <= wr_in.data;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_a_data_out <= RST_OTHER;
         rd_b_data_out <= RST_OTHER;
      end else begin
         rd_a_data_out <= mem_reg[rd_a_idx_in[3:0]];
         rd_b_data_out <= mem_reg[rd_b_idx_in[3:0]];
      end
   end

endmodule

// file: ssp_serial_slave.sv
`timescale 1ns/1ps
module ssp_serial_slave
   import ssp_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           rst_n_in,
   input  wire logic           sclk_in,
   input  wire logic           sen_in,
   input  wire logic           sdi_in,
   input  wire logic [23:0]    rd_data_in,
   output ssp_pkg::ssp_wr_t    wr_out,
   output logic                rd_req_out,
   output logic [5:0]          rd_idx_out,
   output logic                reading_out,
   output logic                sdo_out
);
   import ssp_pkg::*;

   logic [2:0]     sclk_sync_reg;
   logic [1:0]     sen_sync_reg;
   logic [1:0]     sdi_sync_reg;
   ssp_ser_state_t state_reg;
   logic [5:0]     cnt_reg;
   logic [30:0]    shift_reg;
   logic [23:0]    out_reg;
   logic           load_reg;
   logic           sclk_rise;
   logic [6:0]     hdr;

   // -----------------------------------------------------------
   // pin synchronisers; the first stage feeds only the second
   // -----------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sclk_sync_reg <= 3'h0;
         sen_sync_reg  <= 2'h0;
         sdi_sync_reg  <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
         sen_sync_reg  <= {sen_sync_reg[0], sen_in};
         sdi_sync_reg  <= {sdi_sync_reg[0], sdi_in};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
   assign hdr       = {shift_reg[5:0], sdi_sync_reg[1]};

   // -----------------------------------------------------------
   // frame decoder: rw bit, 6-bit address, 24-bit data, pad bit, msb first
   // -----------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg  <= SS_IDLE;
         cnt_reg    <= 6'h00;
         shift_reg  <= 31'h0;
         wr_out     <= '0;
         rd_req_out <= 1'b0;
         rd_idx_out <= 6'h00;
      end else begin
         wr_out.en  <= 1'b0;
         rd_req_out <= 1'b0;
         if (!sen_sync_reg[1]) begin
            // a frame cut short is dropped whole
            state_reg <= SS_IDLE;
            cnt_reg   <= 6'h00;
         end else if (sclk_rise) begin
            shift_reg <= {shift_reg[29:0], sdi_sync_reg[1]};
            cnt_reg   <= cnt_reg + 6'h01;
            case (state_reg)
               SS_IDLE, SS_HEAD: begin
                  state_reg <= SS_HEAD;
                  if (cnt_reg == HDR_LAST_BIT) begin
                     rd_idx_out <= hdr[5:0];
                     rd_req_out <= hdr[6];
                     state_reg  <= hdr[6] ? SS_READ : SS_WRITE;
                  end
               end
               SS_WRITE: begin
                  if (cnt_reg == FRAME_LAST_BIT) begin
                     wr_out.en   <= 1'b1;
                     wr_out.idx  <= shift_reg[29:24];
                     wr_out.data <= shift_reg[23:0];
                     state_reg   <= SS_IDLE;
                  end
               end
               SS_READ: begin
                  if (cnt_reg == FRAME_LAST_BIT) begin
                     state_reg <= SS_IDLE;
                  end
               end
               default: state_reg <= SS_IDLE;
            endcase
         end
      end
   end

   // -----------------------------------------------------------
   // read data shifter, one bit per rising serial clock
   // -----------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         load_reg    <= 1'b0;
         out_reg     <= 24'h000000;
         sdo_out     <= 1'b0;
         reading_out <= 1'b0;
      end else begin
         load_reg <= rd_req_out;
         if (load_reg) begin
            out_reg <= rd_data_in;
         end else if (sclk_rise && state_reg == SS_READ) begin
            sdo_out <= out_reg[23];
            out_reg <= {out_reg[22:0], 1'b0};
         end
         reading_out <= sen_sync_reg[1] && state_reg == SS_READ;
      end
   end

endmodule

// file: ssp_synth_core.sv
`timescale 1ns/1ps
// How it works
// - mode 00/01 drive only during reads
// - mode 10 mixes, mode 11 always gpo
// - fraction after integer in fractional mode starts timed search
// - integer write in integer mode searches
module ssp_synth_core
   import ssp_pkg::*;
#(
   parameter int          SEARCH_WAIT_CYCLES = ssp_pkg::SEARCH_CMP_PERIODS,
   parameter logic [23:0] CHIP_ID            = 24'h00a5a5   // arbitrary value
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   input  wire logic        sclk_in,
   input  wire logic        sen_in,
   input  wire logic        sdi_in,
   output logic             lock_readback_pin_out,
   output logic             lock_readback_pin_oe_out
);
   import ssp_pkg::*;

   localparam logic [31:0] WAIT_LAST = 32'(SEARCH_WAIT_CYCLES - 1);

   ssp_wr_t     ser_wr;
   ssp_wr_t     bus_wr;
   ssp_wr_t     mem_wr;
   logic        ser_rd_req;
   logic [5:0]  ser_rd_idx;
   logic        ser_reading;
   logic        ser_sdo;
   logic [23:0] mem_a_data;
   logic [23:0] mem_b_data;
   logic [23:0] ser_rd_data;
   logic [5:0]  ar_rd_idx;

   logic        aw_full_reg;
   logic [5:0]  aw_idx_reg;
   logic        aw_err_reg;
   logic        w_full_reg;
   logic [23:0] w_data_reg;
   logic        w_any_reg;
   logic        ar_busy_reg;
   logic        ar_stage_reg;
   logic [5:0]  ar_idx_reg;
   logic        ar_err_reg;

   logic [23:0] chipen_reg;
   logic [23:0] mode_reg;
   logic [23:0] afc_reg;
   logic [23:0] rb_reg;
   logic        int_pend_reg;
   logic        busy_reg;
   logic [31:0] wait_cnt_reg;
   logic        search_start;
   logic        lock_det;
   logic        gpo_sel;
   logic [23:0] status_word;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic idx_mapped(input logic [7:0] addr);
      idx_mapped = (addr[1:0] == 2'b00) && (addr[7:2] <= IDX_STATUS);
   endfunction

   function automatic logic wr_hits(input ssp_wr_t w, input logic [5:0] idx);
      wr_hits = w.en && (w.idx == idx);
   endfunction

   // -----------------------------------------------------------
   // serial control port and register storage
   // -----------------------------------------------------------
   ssp_serial_slave u_serial (
      .clk_in      (mclk_in),
      .rst_n_in    (rst_n_in),
      .sclk_in     (sclk_in),
      .sen_in      (sen_in),
      .sdi_in      (sdi_in),
      .rd_data_in  (ser_rd_data),
      .wr_out      (ser_wr),
      .rd_req_out  (ser_rd_req),
      .rd_idx_out  (ser_rd_idx),
      .reading_out (ser_reading),
      .sdo_out     (ser_sdo)
   );

   // the serial port wins a shared cycle; the bus write simply waits
   always_comb begin
      bus_wr.en   = aw_full_reg && w_full_reg && !s_axi_bvalid_out && !ser_wr.en
                    && !aw_err_reg && w_any_reg;
      bus_wr.idx  = aw_idx_reg;
      bus_wr.data = w_data_reg;
      mem_wr      = ser_wr.en ? ser_wr : bus_wr;
   end

   // the memory is read on the address edge so its data stand for the answer
   assign ar_rd_idx = (s_axi_arvalid_in && s_axi_arready_out) ? s_axi_araddr_in[7:2]
                                                              : ar_idx_reg;

   ssp_reg_mem #(
      .DEPTH (MEM_DEPTH)
   ) u_mem (
      .clk_in        (mclk_in),
      .rst_n_in      (rst_n_in),
      .wr_in         (mem_wr),
      .rd_a_idx_in   (ar_rd_idx),
      .rd_b_idx_in   (ser_rd_idx),
      .rd_a_data_out (mem_a_data),
      .rd_b_data_out (mem_b_data)
   );

   always_comb begin
      status_word              = 24'h000000;
      status_word[ST_BUSY_BIT] = busy_reg;
      status_word[ST_LOCK_BIT] = lock_det;
      status_word[ST_PEND_BIT] = int_pend_reg;
   end

   assign ser_rd_data = (ser_rd_idx == IDX_ID) ? CHIP_ID : mem_b_data;

   // -----------------------------------------------------------
   // control shadows of the registers that steer the logic
   // -----------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         chipen_reg <= RST_CHIPEN;
         mode_reg   <= RST_OTHER;
         afc_reg    <= RST_OTHER;
         rb_reg     <= RST_OTHER;
      end else begin
         if (wr_hits(mem_wr, IDX_CHIPEN)) begin
            chipen_reg <= mem_wr.data;
         end
         if (wr_hits(mem_wr, IDX_MODE)) begin
            mode_reg <= mem_wr.data;
         end
         if (wr_hits(mem_wr, IDX_AFC)) begin
            afc_reg <= mem_wr.data;
         end
         if (wr_hits(mem_wr, IDX_READBACK)) begin
            rb_reg <= mem_wr.data;
         end
      end
   end

   // -----------------------------------------------------------
   // automatic segment search
   // -----------------------------------------------------------
   // a fraction write arms a search only after an integer write,
   // so a lone fraction tweak does not disturb the loop
   always_comb begin
      search_start = 1'b0;
      if (!afc_reg[AFC_OFF_BIT]) begin
         if (mode_reg[FRAC_EN_BIT] && int_pend_reg && wr_hits(mem_wr, IDX_FRACDIV)) begin
            search_start = 1'b1;
         end
         if (!mode_reg[FRAC_EN_BIT] && wr_hits(mem_wr, IDX_INTDIV)) begin
            search_start = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         int_pend_reg <= 1'b0;
      end else if (wr_hits(mem_wr, IDX_INTDIV)) begin
         int_pend_reg <= 1'b1;
      end else if (wr_hits(mem_wr, IDX_FRACDIV)) begin
         int_pend_reg <= 1'b0;
      end
   end

   // a restart while busy reloads the full wait
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         busy_reg     <= 1'b0;
         wait_cnt_reg <= 32'h0;
      end else if (search_start) begin
         busy_reg     <= 1'b1;
         wait_cnt_reg <= 32'h0;
      end else if (busy_reg) begin
         if (wait_cnt_reg == WAIT_LAST) begin
            busy_reg <= 1'b0;
         end
         wait_cnt_reg <= wait_cnt_reg + 32'h1;
      end
   end

   assign lock_det = chipen_reg[CHIPEN_BIT] && !busy_reg;
   // only the lock indication and the search flag are wired to gpo
   assign gpo_sel  = (rb_reg[GPO_SEL_W-1:0] == 5'h01) ? lock_det :
                     (rb_reg[GPO_SEL_W-1:0] == 5'h00) ? busy_reg : 1'b0;

   // -----------------------------------------------------------
   // readback pin
   // -----------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         lock_readback_pin_out    <= 1'b0;
         lock_readback_pin_oe_out <= 1'b0;
      end else begin
         case (ssp_rb_mode_t'(rb_reg[RB_MODE_HI:RB_MODE_LO]))
            RB_DATA_HIZ: begin
               lock_readback_pin_out    <= ser_sdo;
               lock_readback_pin_oe_out <= ser_reading;
            end
            RB_GPO_HIZ: begin
               lock_readback_pin_out    <= gpo_sel;
               lock_readback_pin_oe_out <= ser_reading;
            end
            RB_DATA_GPO: begin
               lock_readback_pin_out    <= ser_reading ? ser_sdo : gpo_sel;
               lock_readback_pin_oe_out <= 1'b1;
            end
            RB_GPO_ALWAYS: begin
               lock_readback_pin_out    <= gpo_sel;
               lock_readback_pin_oe_out <= 1'b1;
            end
            default: begin
               lock_readback_pin_out    <= 1'b0;
               lock_readback_pin_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------
   // axi4-lite write channels
   // -----------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         aw_full_reg <= 1'b0;
         aw_idx_reg  <= 6'h00;
         aw_err_reg  <= 1'b0;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_full_reg <= 1'b1;
         aw_idx_reg  <= s_axi_awaddr_in[7:2];
         aw_err_reg  <= !idx_mapped(s_axi_awaddr_in);
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         aw_full_reg <= 1'b0;
      end
   end

   // partial strobes are not merged: any strobe in the low three bytes writes the whole word
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 24'h000000;
         w_any_reg  <= 1'b0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata_in[23:0];
         w_any_reg  <= |s_axi_wstrb_in[2:0];
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= RESP_OKAY;
      end else begin
         s_axi_awready_out <= !aw_full_reg && !(s_axi_awvalid_in && s_axi_awready_out);
         s_axi_wready_out  <= !w_full_reg && !(s_axi_wvalid_in && s_axi_wready_out);
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end else if (aw_full_reg && w_full_reg && !s_axi_bvalid_out
                      && (aw_err_reg || !ser_wr.en)) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= aw_err_reg ? RESP_SLVERR : RESP_OKAY;
         end
      end
   end

   // -----------------------------------------------------------
   // axi4-lite read channels
   // -----------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ar_busy_reg       <= 1'b0;
         ar_stage_reg      <= 1'b0;
         ar_idx_reg        <= 6'h00;
         ar_err_reg        <= 1'b0;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0;
         s_axi_rresp_out   <= RESP_OKAY;
      end else begin
         s_axi_arready_out <= !ar_busy_reg && !(s_axi_arvalid_in && s_axi_arready_out);
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            ar_busy_reg  <= 1'b1;
            ar_stage_reg <= 1'b1;
            ar_idx_reg   <= s_axi_araddr_in[7:2];
            ar_err_reg   <= !idx_mapped(s_axi_araddr_in);
         end else if (ar_stage_reg) begin
            ar_stage_reg     <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= ar_err_reg ? RESP_SLVERR : RESP_OKAY;
            if (ar_err_reg) begin
               s_axi_rdata_out <= 32'h0;
            end else if (ar_idx_reg == IDX_ID) begin
               s_axi_rdata_out <= {8'h00, CHIP_ID};
            end else if (ar_idx_reg == IDX_STATUS) begin
               s_axi_rdata_out <= {8'h00, status_word};
            end else begin
               s_axi_rdata_out <= {8'h00, mem_a_data};
            end
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            ar_busy_reg      <= 1'b0;
         end
      end
   end

endmodule

// file: ssp_synth_core_monitor.sv
`timescale 1ns/1ps
module ssp_synth_core_monitor
   import ssp_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  s_axi_awaddr_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic        sen_in,
   input wire logic        lock_readback_pin_oe_out
);
   logic [1:0] mode_reg;
   logic [3:0] quiet_reg;
   logic       mode_wr;
   // mode is only tracked through the register bus, not serial writes
   assign mode_wr = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
                    && s_axi_wready_out && (s_axi_awaddr_in == 8'h3c);
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in)
         mode_reg <= 2'b00;
      else if (mode_wr)
         mode_reg <= s_axi_wdata_in[7:6];
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || sen_in || mode_wr)
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
         quiet_reg <= quiet_reg + 4'h1;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RB_IDLE_HIZ: assert property (quiet_reg > 4'd7 && !mode_reg[1] |->
      !lock_readback_pin_oe_out) else $error("pin driven while idle");
   AST_RB_IDLE_GPO: assert property (quiet_reg > 4'd7 && mode_reg[1] |->
      lock_readback_pin_oe_out) else $error("pin idle while gpo mode");
   AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("bvalid dropped");
   AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
      else $error("rvalid dropped");
   AST_R_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
      !s_axi_rvalid_out ##1 s_axi_rvalid_out) else $error("read latency");
endmodule
bind ssp_synth_core ssp_synth_core_monitor u_mon (.*);

// file: tb_ssp_synth_core.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
module tb_ssp_synth_core;
   import ssp_pkg::*;
   localparam logic [23:0] ID = 24'h00c3c3;   // arbitrary value
   logic        mclk_in = 0, rst_n_in = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d, seed = 32'd73490;
   logic [1:0]  bresp, rresp;
   logic        awr, wr_r, bv, arr, rv, sclk, sen, sdi, pin, oe;
   logic [23:0] q, n, prev = 24'hc8;
   int          failures = 0, comparisons = 0;
   always #12.5 mclk_in = ~mclk_in;
   ssp_synth_core #(.SEARCH_WAIT_CYCLES(20), .CHIP_ID(ID)) dut (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd_d),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
      .sclk_in(sclk), .sen_in(sen), .sdi_in(sdi), .lock_readback_pin_out(pin),
      .lock_readback_pin_oe_out(oe));
   ssp_host_model u_host (.pin_in(pin), .oe_in(oe), .sclk_out(sclk), .sen_out(sen),
      .sdi_out(sdi));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      logic ah = 0, wh = 0, ta, tw;
      int k = 0;
      @(posedge mclk_in);
      {awa, wd, awv, wv, br} <= {a, d, 3'b111};
      while (!(ah && wh) && k++ < 100) begin
         @(negedge mclk_in);
         {ta, tw} = {awr === 1'b1, wr_r === 1'b1};
         @(posedge mclk_in);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         {ah, wh} = {ah | ta, wh | tw};
      end
      do @(negedge mclk_in); while (bv !== 1'b1 && k++ < 200);
      if (k > 200) failures++;
      `CHK(bresp, er)
      @(posedge mclk_in) br <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [23:0] e, input logic [1:0] er = RESP_OKAY,
                     input logic [23:0] m = 24'hffffff);
      int k = 0;
      @(posedge mclk_in);
      {ara, arv, rr} <= {a, 2'b11};
      do @(negedge mclk_in); while (arr !== 1'b1 && k++ < 100);
      @(posedge mclk_in) arv <= 0;
      do @(negedge mclk_in); while (rv !== 1'b1 && k++ < 200);
      if (k > 200) failures++;
      `CHK(rd_d[23:0] & m, e)
      `CHK(rresp, er)
      @(posedge mclk_in) rr <= 0;
   endtask
   task automatic sw(input logic [5:0] i, input logic [23:0] d);
      logic [23:0] x;
      u_host.frame(1'b0, i, d, x);
   endtask
   task results();
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      results();
   end
   initial begin
      static logic [29:0] ini[14] = '{{6'h01, 24'h2}, {6'h02, 24'h2}, {6'h05, 24'h0f88},
         {6'h05, 24'he090}, {6'h05, 24'h3898}, {6'h05, 24'ha0a0}, {6'h05, 24'h5528},
         {6'h05, 24'h7fb0}, {6'h07, 24'h14d}, {6'h08, 24'hc1beff}, {6'h09, 24'h5af264},
         {6'h0a, 24'h2041}, {6'h0b, 24'h7c021}, {6'h0f, 24'h01}};
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1;
      repeat (3) @(posedge mclk_in);
      rd(8'h00, ID);
      rd(8'h0c, 24'hc8);
      rd(8'h44, 24'h0, RESP_SLVERR);
      wr(8'h44, 32'h1, RESP_SLVERR);
      wr(8'h00, 32'h1);
      rd(8'h00, ID);
      foreach (ini[k]) sw(ini[k][29:24], ini[k][23:0]);
      rd(8'h14, 24'h7fb0);
      for (int h = 0; h < 2; h++) begin
         n = 24'd24 + rnd() % 200;
         sw(6'h06, 24'h200b42);
         sw(6'h05, 24'h5f00);
         sw(6'h03, prev | n);
         sw(6'h03, n);
         rd(8'h40, 24'h4, RESP_OKAY, 24'h5);
         sw(6'h04, rnd());
         rd(8'h40, 24'h1, RESP_OKAY, 24'h1);
         repeat (40) @(posedge mclk_in);
         rd(8'h40, 24'h2, RESP_OKAY, 24'h3);
         sw(6'h06, 24'h200b4a);
         prev = n;
      end
      sw(6'h02, 24'h01);
      sw(6'h09, 24'h1af264);
      sw(6'h0b, 24'h7c061);
      rd(8'h2c, 24'h7c061);
      sw(6'h03, 24'hcc);
      sw(6'h06, 24'h2003ca);
      sw(6'h03, 24'h8c);
      rd(8'h40, 24'h1, RESP_OKAY, 24'h1);
      repeat (40) @(posedge mclk_in);
      prev = 24'h8c;
      for (int h = 0; h < 2; h++) begin
         n = 24'd24 + rnd() % 200;
         sw(6'h0a, 24'h2841);
         sw(6'h03, prev | n);
         rd(8'h40, 24'h0, RESP_OKAY, 24'h1);
         sw(6'h0a, 24'h2041);
         sw(6'h03, n);
         rd(8'h40, 24'h1, RESP_OKAY, 24'h1);
         repeat (40) @(posedge mclk_in);
         prev = n;
      end
      for (int m = 0; m < 4; m++) begin
         wr(8'h3c, m << 6 | 1);
         u_host.frame(1'b1, 6'h03, 24'h0, q);
         `CHK(q, m[0] ? 24'hffffff : prev)
         repeat (8) @(posedge mclk_in);
         `CHK(oe, m[1])
      end
      repeat (4) begin
         n = rnd();
         wr(8'h1c, n);
         rd(8'h1c, n);
      end
      results();
   end
endmodule
